//--- logic/bst_pkg.sv
// shared constants, states and pin carrier for the boundary-scan test port
package bst_pkg;
	localparam int BST_IR_W = 8;
	localparam int BST_DR_W = 8;
	localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 8'h81;
	localparam logic [BST_IR_W-1:0] BST_IR_BYPASS = 8'hff;
	localparam logic BST_BYP_CAPTURE = 1'h0;

	// standard sixteen-state controller, codes written out
	typedef enum logic [3:0] {
		ST_EXIT2_DR = 4'h0,
		ST_EXIT1_DR = 4'h1,
		ST_SHIFT_DR = 4'h2,
		ST_PAUSE_DR = 4'h3,
		ST_SEL_IR = 4'h4,
		ST_UPDATE_DR = 4'h5,
		ST_CAPTURE_DR = 4'h6,
		ST_SEL_DR = 4'h7,
		ST_EXIT2_IR = 4'h8,
		ST_EXIT1_IR = 4'h9,
		ST_SHIFT_IR = 4'ha,
		ST_PAUSE_IR = 4'hb,
		ST_IDLE = 4'hc,
		ST_UPDATE_IR = 4'hd,
		ST_CAPTURE_IR = 4'he,
		ST_RESET = 4'hf
	} bst_state_t;

	// the three test-port inputs travel together through the synchroniser
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bst_pins_t;
endpackage : bst_pkg

//--- logic/bst_tap.sv
// boundary-scan test access port: controller, instruction, bypass and boundary stages
`timescale 1ns/10ps
module bst_tap import bst_pkg::*; #(
	parameter int DR_W = BST_DR_W
) (
	input wire logic i_sys_clk, // system clock, 125 MHz
	input wire logic i_rstn, // asynchronous reset, active low
	input wire logic i_tck, // test clock pin
	input wire logic i_tms, // test mode select pin
	input wire logic i_tdi, // test data in pin
	input wire logic [DR_W-1:0] i_func_in, // normal-function input pins
	output logic o_tdo, // test data out
	output logic o_tdo_oe, // high while test data out is driven
	output logic [DR_W-1:0] o_func_out // normal-function output pins
);
	bst_pins_t pin_s1_reg;
	bst_pins_t pin_s2_reg;
	logic [DR_W-1:0] func_s1_reg;
	logic [DR_W-1:0] func_s2_reg;
	logic tck_d_reg;
	bst_state_t state_reg;
	bst_state_t state_next;
	logic [BST_IR_W-1:0] ir_shift_reg;
	logic [BST_IR_W-1:0] ir_latch_reg;
	logic byp_reg;
	logic [DR_W-1:0] bsr_shift_reg;
	logic [DR_W-1:0] func_out_reg;
	logic tdo_reg;
	logic tdo_oe_reg;

	// two-stage synchronisers; first stage is read only by the second
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			func_s1_reg <= '0;
			func_s2_reg <= '0;
			tck_d_reg <= 1'h0;
		end else begin
			pin_s1_reg <= '{tck: i_tck, tms: i_tms, tdi: i_tdi};
			pin_s2_reg <= pin_s1_reg;
			func_s1_reg <= i_func_in;
			func_s2_reg <= func_s1_reg;
			tck_d_reg <= pin_s2_reg.tck;
		end
	end

	// edge detection and decodes
	wire tck_rise = pin_s2_reg.tck & ~tck_d_reg;
	wire tck_fall = ~pin_s2_reg.tck & tck_d_reg;
	wire tms_s = pin_s2_reg.tms;
	wire tdi_s = pin_s2_reg.tdi;
	wire bypass_sel = (ir_latch_reg == BST_IR_BYPASS);
	wire in_shift = (state_reg == ST_SHIFT_IR) || (state_reg == ST_SHIFT_DR);
	wire in_exit1 = (state_reg == ST_EXIT1_IR) || (state_reg == ST_EXIT1_DR);
	wire dr_out_bit = bypass_sel ? byp_reg : bsr_shift_reg[0];
	wire tdo_src = (state_reg == ST_SHIFT_IR) ? ir_shift_reg[0] : dr_out_bit;

	// next state of the controller; mode select is stable at the rise
	always_comb begin
		case (state_reg)
			ST_RESET: state_next = tms_s ? ST_RESET : ST_IDLE;
			ST_IDLE: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAPTURE_DR;
			ST_CAPTURE_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: state_next = tms_s ? ST_UPDATE_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: state_next = tms_s ? ST_UPDATE_DR : ST_SHIFT_DR;
			ST_UPDATE_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: state_next = tms_s ? ST_RESET : ST_CAPTURE_IR;
			ST_CAPTURE_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: state_next = tms_s ? ST_UPDATE_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: state_next = tms_s ? ST_UPDATE_IR : ST_SHIFT_IR;
			ST_UPDATE_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
			default: state_next = ST_RESET;
		endcase
	end

	// controller advances only on test clock rise
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_RESET;
		end else if (tck_rise) begin
			state_reg <= state_next;
		end
	end

	// instruction shift stage: capture fixed pattern, shift lsb first
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ir_shift_reg <= BST_IR_CAPTURE;
		end else if (tck_rise && state_reg == ST_CAPTURE_IR) begin
			ir_shift_reg <= BST_IR_CAPTURE;
		end else if (tck_rise && state_reg == ST_SHIFT_IR) begin
			ir_shift_reg <= {tdi_s, ir_shift_reg[BST_IR_W-1:1]};
		end
	end

	// active instruction; reset state forces bypass so scans start safe
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ir_latch_reg <= BST_IR_BYPASS;
		end else if (state_reg == ST_RESET) begin
			ir_latch_reg <= BST_IR_BYPASS;
		end else if (tck_fall && state_reg == ST_UPDATE_IR) begin
			ir_latch_reg <= ir_shift_reg;
		end
	end

	// single-stage bypass register
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			byp_reg <= BST_BYP_CAPTURE;
		end else if (tck_rise && state_reg == ST_CAPTURE_DR) begin
			byp_reg <= BST_BYP_CAPTURE;
		end else if (tck_rise && state_reg == ST_SHIFT_DR) begin
			byp_reg <= tdi_s;
		end
	end

	// boundary shift stages used by any non-bypass instruction
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bsr_shift_reg <= '0;
		end else if (tck_rise && !bypass_sel && state_reg == ST_CAPTURE_DR) begin
			bsr_shift_reg <= func_s2_reg;
		end else if (tck_rise && !bypass_sel && state_reg == ST_SHIFT_DR) begin
			bsr_shift_reg <= {tdi_s, bsr_shift_reg[DR_W-1:1]};
		end
	end

	// update stage drives function outputs on the fall only
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			func_out_reg <= '0;
		end else if (tck_fall && !bypass_sel && state_reg == ST_UPDATE_DR) begin
			func_out_reg <= bsr_shift_reg;
		end
	end

	// serial out and its enable change on the fall; hold otherwise
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tdo_reg <= 1'h0;
			tdo_oe_reg <= 1'h0;
		end else if (tck_fall && in_shift) begin
			tdo_reg <= tdo_src;
			tdo_oe_reg <= 1'h1;
		end else if (tck_fall && in_exit1) begin
			tdo_oe_reg <= 1'h0;
		end
	end

	assign o_tdo = tdo_reg;
	assign o_tdo_oe = tdo_oe_reg;
	assign o_func_out = func_out_reg;

	// checks, all in the system clock domain
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_rise_in_shift_ir_end;
		tck_rise && state_reg == ST_SHIFT_IR && tms_s;
	endsequence
	sequence s_fall_in_update_ir;
		tck_fall && state_reg == ST_UPDATE_IR;
	endsequence
	sequence s_rise_in_shift_dr;
		tck_rise && state_reg == ST_SHIFT_DR;
	endsequence

	a_state_on_rise: assert property ($changed(state_reg) |-> $past(tck_rise))
		else $error("state moved without a test clock rise");
	a_tdo_on_fall: assert property (($changed(o_tdo) || $changed(o_tdo_oe)) |-> $past(tck_fall))
		else $error("data out changed without a test clock fall");
	a_ir_capture_val: assert property (
		tck_rise && state_reg == ST_CAPTURE_IR |=> ir_shift_reg == BST_IR_CAPTURE)
		else $error("capture did not load 10000001");
	a_tdo_enable_shift: assert property (tck_fall && in_shift |=> o_tdo_oe && o_tdo == $past(tdo_src))
		else $error("data out not enabled in shift");
	a_tdo_float_exit: assert property (tck_fall && in_exit1 |=> !o_tdo_oe)
		else $error("data out not floated in exit1");
	a_ir_last_bit: assert property (
		s_rise_in_shift_ir_end |=> state_reg == ST_EXIT1_IR && ir_shift_reg[BST_IR_W-1] == $past(tdi_s))
		else $error("last instruction bit lost");
	a_ir_update_latch: assert property (s_fall_in_update_ir |=> ir_latch_reg == $past(ir_shift_reg))
		else $error("instruction latch not updated");
	a_bypass_select: assert property (
		s_fall_in_update_ir ##0 (ir_shift_reg == BST_IR_BYPASS) |=> bypass_sel)
		else $error("all ones did not select bypass");
	a_byp_capture_zero: assert property (
		tck_rise && state_reg == ST_CAPTURE_DR |=> byp_reg == BST_BYP_CAPTURE)
		else $error("bypass did not capture zero");
	a_byp_one_stage: assert property (s_rise_in_shift_dr ##0 bypass_sel |=> byp_reg == $past(tdi_s))
		else $error("bypass delay not one stage");
	a_dr_update_out: assert property (
		tck_fall && state_reg == ST_UPDATE_DR && !bypass_sel |=> o_func_out == $past(bsr_shift_reg))
		else $error("data register not updated");
	// function outputs move only on a fall, like the serial out
	a_func_on_fall: assert property ($changed(o_func_out) |-> $past(tck_fall))
		else $error("function outputs changed without a test clock fall");
	// pause and exit2 must leave the stages alone so a split scan resumes in place
	a_pause_keeps_dr: assert property (
		tck_rise && (state_reg == ST_PAUSE_DR || state_reg == ST_EXIT2_DR) |=> $stable(bsr_shift_reg) && $stable(byp_reg))
		else $error("data stages moved outside shift");
	a_reset_to_idle: assert property (tck_rise && state_reg == ST_RESET && !tms_s |=> state_reg == ST_IDLE)
		else $error("reset state did not go idle");
	a_return_reset: assert property (tck_rise && state_reg == ST_SEL_IR && tms_s |=> state_reg == ST_RESET)
		else $error("select-IR with high select missed reset");
endmodule : bst_tap

//--- bench/bst_ctl_model.sv
// behavioural boundary-scan controller driving the test port pins
`timescale 1ns/10ps
module bst_ctl_model (
	input wire logic i_sys_clk, // system clock, pins move on its falling edge
	input wire logic i_tdo, // serial data from the port
	input wire logic i_tdo_oe, // serial out driver enable
	output logic o_tck, // test clock, still low between frames
	output logic o_tms, // mode select
	output logic o_tdi // serial data to the port
);
	initial begin
		o_tck = 1'h0;
		o_tms = 1'h1;
		o_tdi = 1'h0;
	end
	// one 160 ns test clock cycle: set pins while low, rise, fall, then sample the answer
	task automatic cycle(input logic tms, input logic tdi, output logic tdo, output logic oe);
		@(negedge i_sys_clk);
		o_tms = tms;
		o_tdi = tdi;
		// pins settle three system cycles before the rise; 80 ns low, 80 ns high
		repeat (3) @(negedge i_sys_clk);
		o_tck = 1'h1;
		repeat (10) @(negedge i_sys_clk);
		o_tck = 1'h0;
		// answer lands 2..3 system cycles after the fall
		repeat (6) @(negedge i_sys_clk);
		// a floated line reads back inverted, so a stale held value cannot pass
		tdo = i_tdo_oe ? i_tdo : ~i_tdo;
		oe = i_tdo_oe;
		o_tdi = ~tdi; // bit no longer valid, so the line must not keep it
	endtask : cycle
endmodule : bst_ctl_model

//--- bench/bst_tap_tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
module bst_tap_tb import bst_pkg::*;;
	logic i_sys_clk, i_rstn, tck, tms, tdi, o_tdo, o_tdo_oe, last_tdo;
	logic [BST_DR_W-1:0] i_func_in, o_func_out;
	int error_cnt = 0;
	int cmp_count = 0;
	bst_tap u_bst_tap (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_func_in(i_func_in), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_func_out(o_func_out));
	bst_ctl_model u_bst_ctl_model (.i_sys_clk(i_sys_clk), .i_tdo(o_tdo), .i_tdo_oe(o_tdo_oe),
		.o_tck(tck), .o_tms(tms), .o_tdi(tdi));
	task automatic chk(input logic [7:0] act, input logic [7:0] exp);
		cmp_count++;
		if (act !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : chk
	// one test clock cycle, driver enable judged after its fall
	task automatic step(input logic tms_v, input logic tdi_v, input logic oe_exp);
		logic oe;
		u_bst_ctl_model.cycle(tms_v, tdi_v, last_tdo, oe);
		chk({7'h0, oe}, {7'h0, oe_exp});
	endtask : step
	// from idle through one scan of n bits and back to idle
	task automatic scan(input logic ir, input logic [7:0] din, input logic [7:0] exp, input int n);
		step(1'h1, 1'h0, 1'h0);
		if (ir) step(1'h1, 1'h0, 1'h0);
		step(1'h0, 1'h0, 1'h0);
		step(1'h0, 1'h0, 1'h1);
		chk({7'h0, last_tdo}, {7'h0, exp[0]});
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], i != n - 1);
			if (i != n - 1) chk({7'h0, last_tdo}, {7'h0, exp[i + 1]});
		end
		step(1'h1, 1'h0, 1'h0);
		step(1'h0, 1'h0, 1'h0);
	endtask : scan
	// the plain walk: bypass loaded, three bits through the bypass stage
	task automatic t_walk();
		step(1'h0, 1'h0, 1'h0);
		scan(1'h1, 8'hff, BST_IR_CAPTURE, 8);
		scan(1'h0, 8'h05, 8'h02, 3);
		chk(o_func_out, 8'h00);
		repeat (3) step(1'h1, 1'h0, 1'h0);
	endtask : t_walk
	// 0x7f is bypass only if the eighth bit were lost
	task automatic t_boundary();
		i_func_in = 8'ha5;
		step(1'h0, 1'h0, 1'h0);
		scan(1'h1, 8'h7f, BST_IR_CAPTURE, 8);
		scan(1'h0, 8'h3c, 8'ha5, 8);
		chk(o_func_out, 8'h3c);
	endtask : t_boundary
	// five highs reach reset from anywhere, which restores bypass
	task automatic t_reset();
		repeat (5) step(1'h1, 1'h0, 1'h0);
		step(1'h0, 1'h0, 1'h0);
		scan(1'h0, 8'h01, 8'h02, 2);
		chk(o_func_out, 8'h3c);
	endtask : t_reset
	// a boundary scan split by a pause keeps its place in the stages
	task automatic t_pause();
		logic [7:0] cap;
		logic [7:0] din;
		cap = 8'h5a;
		din = 8'hc3;
		i_func_in = cap;
		scan(1'h1, 8'h00, BST_IR_CAPTURE, 8);
		step(1'h1, 1'h0, 1'h0);
		step(1'h0, 1'h0, 1'h0);
		step(1'h0, 1'h0, 1'h1);
		chk({7'h0, last_tdo}, {7'h0, cap[0]});
		for (int i = 0; i < 8; i++) begin
			step(i == 3 || i == 7, din[i], i != 3 && i != 7);
			if (i == 3) begin
				step(1'h0, 1'h0, 1'h0);
				step(1'h0, 1'h0, 1'h0);
				step(1'h1, 1'h0, 1'h0);
				step(1'h0, 1'h0, 1'h1);
			end
			if (i != 7) chk({7'h0, last_tdo}, {7'h0, cap[i + 1]});
		end
		step(1'h1, 1'h0, 1'h0);
		step(1'h0, 1'h0, 1'h0);
		chk(o_func_out, din);
	endtask : t_pause
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		i_sys_clk = 1'h0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	initial begin
		i_rstn = 1'h0;
		i_func_in = 8'h00;
		repeat (2) @(negedge i_sys_clk);
		i_rstn = 1'h1;
		repeat (3) @(negedge i_sys_clk);
		t_walk();
		t_boundary();
		t_reset();
		t_pause();
		print_verdict();
	end
	// watchdog: the run needs about 100 test clock cycles, some 16 us
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
endmodule : bst_tap_tb
